/* inc/fcsm_pkg.sv */
// package: command codes, states and carriers for the command state machine
package fcsm_pkg;

	// command codes written by the host
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_WORD_PGM_A  = 8'h10;
	localparam logic [7:0] CMD_WORD_PGM_B  = 8'h40;
	localparam logic [7:0] CMD_BUF_PGM     = 8'hE8;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_FACT_SETUP  = 8'h80;
	localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
	localparam logic [7:0] CMD_READ_ID     = 8'h90;
	localparam logic [7:0] CMD_QUERY       = 8'h98;
	localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;

	// partition and buffer sizing
	localparam int          PART_W     = 3;
	localparam int          NUM_PART   = 8;
	localparam int          WCNT_W     = 5;
	localparam logic [4:0]  WCNT_ZERO  = 5'h0;
	localparam logic [4:0]  WCNT_ONE   = 5'h1;

	// per-partition read output state
	typedef enum logic [1:0] {
		FCSM_RD_ARRAY  = 2'b00,
		FCSM_RD_ID     = 2'b01,
		FCSM_RD_QUERY  = 2'b10,
		FCSM_RD_STATUS = 2'b11
	} fcsm_rd_e;

	localparam fcsm_rd_e RD_RESET = FCSM_RD_ARRAY;

	// chip state of the command state machine
	typedef enum logic [4:0] {
		FCSM_READY        = 5'b00000,
		FCSM_LOCK_SETUP   = 5'b00001,
		FCSM_WP_SETUP     = 5'b00010,
		FCSM_WP_BUSY      = 5'b00011,
		FCSM_WP_SUSP      = 5'b00100,
		FCSM_BP_SETUP     = 5'b00101,
		FCSM_BP_LOAD1     = 5'b00110,
		FCSM_BP_LOAD2     = 5'b00111,
		FCSM_BP_CONFIRM   = 5'b01000,
		FCSM_BP_BUSY      = 5'b01001,
		FCSM_BP_SUSP      = 5'b01010,
		FCSM_ER_SETUP     = 5'b01011,
		FCSM_ER_BUSY      = 5'b01100,
		FCSM_ER_SUSP      = 5'b01101,
		FCSM_ES_WP_SETUP  = 5'b01110,
		FCSM_ES_WP_BUSY   = 5'b01111,
		FCSM_ES_WP_SUSP   = 5'b10000,
		FCSM_ES_BP_SETUP  = 5'b10001,
		FCSM_ES_BP_LOAD1  = 5'b10010,
		FCSM_ES_BP_LOAD2  = 5'b10011,
		FCSM_ES_BP_CONF   = 5'b10100,
		FCSM_ES_BP_BUSY   = 5'b10101,
		FCSM_ES_BP_SUSP   = 5'b10110,
		FCSM_ES_LOCK      = 5'b10111,
		FCSM_FACT_SETUP   = 5'b11000
	} fcsm_state_e;

	// one host bus write
	typedef struct packed {
		logic                 valid;
		logic [PART_W-1:0]    part;
		logic [7:0]           code;
	} fcsm_cmd_s;

endpackage : fcsm_pkg

/* rtl/fcsm_rd_mem.sv */
// per-partition read output state store
`timescale 1ns/1ps
module fcsm_rd_mem (
	// clock and reset
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_rst_n,
	// write side
	input  wire logic                          i_we,
	input  wire logic [fcsm_pkg::PART_W-1:0]   i_wpart,
	input  wire fcsm_pkg::fcsm_rd_e            i_wdata,
	// read side
	input  wire logic [fcsm_pkg::PART_W-1:0]   i_rpart,
	output fcsm_pkg::fcsm_rd_e                 o_rdata
);

	fcsm_pkg::fcsm_rd_e mem [fcsm_pkg::NUM_PART];

	genvar g;
	generate
		for (g = 0; g < fcsm_pkg::NUM_PART; g++) begin : g_part
			always_ff @(posedge i_sys_clk) begin
				if (!i_rst_n)
					mem[g] <= fcsm_pkg::RD_RESET;
				else if (i_we && i_wpart == g[fcsm_pkg::PART_W-1:0])
					mem[g] <= i_wdata;
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_rdata <= fcsm_pkg::RD_RESET;
		else
			o_rdata <= mem[i_rpart];
	end

endmodule : fcsm_rd_mem

/* rtl/fcsm_top.sv */
// Summary of operation
// - only one partition may own a program or erase at any moment.
// - each partition keeps its last read output state until changed.
// - the next chip state ignores every partition's read output state.
// - after the query command the partition reads the query database.
// - ready takes 10/40, E8, 20, 80, 60 into their setups, else stays.
// - the next state is a function of current state, command, word count and engine done only.
// - buffered load takes the announced word count, then awaits confirm.
// - B0 suspends a busy word program; done ends it; anything else keeps it busy.
// - D0 resumes a suspended word program; anything else keeps it.
// - erase suspend nests program, buffered program, lock; D0 resumes.
`timescale 1ns/1ps
module fcsm_top (
	// clock and reset
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_rst_n,
	// host command and data writes
	input  wire fcsm_pkg::fcsm_cmd_s           i_cmd,
	// read output selection
	input  wire logic [fcsm_pkg::PART_W-1:0]   i_rd_part,
	output fcsm_pkg::fcsm_rd_e                 o_rd_state,
	// array engine handshake
	input  wire logic                          i_op_done,
	// chip state and status
	output fcsm_pkg::fcsm_state_e              o_state,
	output logic [fcsm_pkg::PART_W-1:0]        o_op_part,
	output logic                               o_busy,
	output logic                               o_seq_error,
	output logic                               o_lock_error
);

	fcsm_pkg::fcsm_state_e state;
	fcsm_pkg::fcsm_state_e next_state;
	logic [fcsm_pkg::WCNT_W-1:0] wcnt;
	logic [fcsm_pkg::WCNT_W-1:0] next_wcnt;
	logic                        next_seq_err;
	logic                        next_lock_err;

	// decode used in several places
	function automatic logic is_wp(input logic [7:0] c);
		is_wp = (c == fcsm_pkg::CMD_WORD_PGM_A) ||
		        (c == fcsm_pkg::CMD_WORD_PGM_B);
	endfunction : is_wp

	function automatic logic is_busy(input fcsm_pkg::fcsm_state_e s);
		case (s)
			fcsm_pkg::FCSM_WP_BUSY,
			fcsm_pkg::FCSM_BP_BUSY,
			fcsm_pkg::FCSM_ER_BUSY,
			fcsm_pkg::FCSM_ES_WP_BUSY,
			fcsm_pkg::FCSM_ES_BP_BUSY: is_busy = 1'b1;
			default:                   is_busy = 1'b0;
		endcase
	endfunction : is_busy

	wire       wr      = i_cmd.valid;
	wire [7:0] code    = i_cmd.code;
	wire       c_d0    = wr && code == fcsm_pkg::CMD_CONFIRM;
	wire       c_b0    = wr && code == fcsm_pkg::CMD_SUSPEND;
	wire       c_wp    = wr && is_wp(code);
	wire       c_bp    = wr && code == fcsm_pkg::CMD_BUF_PGM;
	wire       c_er    = wr && code == fcsm_pkg::CMD_ERASE_SETUP;
	wire       c_fact  = wr && code == fcsm_pkg::CMD_FACT_SETUP;
	wire       c_lock  = wr && code == fcsm_pkg::CMD_LOCK_SETUP;
	// an operation ends when the engine reports done while busy
	wire       done    = i_op_done && is_busy(state);
	// word count of buffered load is count-1 in the first load write
	wire [fcsm_pkg::WCNT_W-1:0] load_cnt = code[fcsm_pkg::WCNT_W-1:0];
	wire       load_last = (wcnt == fcsm_pkg::WCNT_ZERO);

	// next state from state, command, word count and engine done, no read state input
	always_comb begin
		next_state    = state;
		next_wcnt     = wcnt;
		next_seq_err  = 1'b0;
		next_lock_err = 1'b0;
		case (state)
			fcsm_pkg::FCSM_READY: begin
				if (c_wp)
					next_state = fcsm_pkg::FCSM_WP_SETUP;
				else if (c_bp)
					next_state = fcsm_pkg::FCSM_BP_SETUP;
				else if (c_er)
					next_state = fcsm_pkg::FCSM_ER_SETUP;
				else if (c_fact)
					next_state = fcsm_pkg::FCSM_FACT_SETUP;
				else if (c_lock)
					next_state = fcsm_pkg::FCSM_LOCK_SETUP;
			end
			fcsm_pkg::FCSM_LOCK_SETUP: if (wr) begin
				next_state    = fcsm_pkg::FCSM_READY;
				next_lock_err = !c_d0 && code != fcsm_pkg::CMD_LOCK_SETUP &&
				                code != 8'h01 && code != 8'h2F &&
				                code != 8'h03;
			end
			fcsm_pkg::FCSM_FACT_SETUP: if (wr) begin
				// factory loading is not carried by this block
				next_state   = fcsm_pkg::FCSM_READY;
				next_seq_err = 1'b1;
			end
			fcsm_pkg::FCSM_WP_SETUP:
				if (wr) next_state = fcsm_pkg::FCSM_WP_BUSY;
			fcsm_pkg::FCSM_WP_BUSY:
				if (c_b0) next_state = fcsm_pkg::FCSM_WP_SUSP;
				else if (done) next_state = fcsm_pkg::FCSM_READY;
			fcsm_pkg::FCSM_WP_SUSP:
				if (c_d0) next_state = fcsm_pkg::FCSM_WP_BUSY;
			fcsm_pkg::FCSM_BP_SETUP,
			fcsm_pkg::FCSM_ES_BP_SETUP: if (wr) begin
				next_state = (state == fcsm_pkg::FCSM_BP_SETUP) ?
				             fcsm_pkg::FCSM_BP_LOAD1 :
				             fcsm_pkg::FCSM_ES_BP_LOAD1;
				next_wcnt  = load_cnt;
			end
			fcsm_pkg::FCSM_BP_LOAD1,
			fcsm_pkg::FCSM_BP_LOAD2,
			fcsm_pkg::FCSM_ES_BP_LOAD1,
			fcsm_pkg::FCSM_ES_BP_LOAD2: if (wr) begin
				// every write here is a data word, whatever its value
				next_wcnt = wcnt - fcsm_pkg::WCNT_ONE;
				if (load_last)
					next_state = (state == fcsm_pkg::FCSM_BP_LOAD1 ||
					              state == fcsm_pkg::FCSM_BP_LOAD2) ?
					             fcsm_pkg::FCSM_BP_CONFIRM :
					             fcsm_pkg::FCSM_ES_BP_CONF;
				else
					next_state = (state == fcsm_pkg::FCSM_BP_LOAD1 ||
					              state == fcsm_pkg::FCSM_BP_LOAD2) ?
					             fcsm_pkg::FCSM_BP_LOAD2 :
					             fcsm_pkg::FCSM_ES_BP_LOAD2;
			end
			fcsm_pkg::FCSM_BP_CONFIRM: if (wr) begin
				next_state   = c_d0 ? fcsm_pkg::FCSM_BP_BUSY :
				               fcsm_pkg::FCSM_READY;
				next_seq_err = !c_d0;
			end
			fcsm_pkg::FCSM_ES_BP_CONF: if (wr) begin
				// abort inside a suspend falls back to the suspend
				next_state   = c_d0 ? fcsm_pkg::FCSM_ES_BP_BUSY :
				               fcsm_pkg::FCSM_ER_SUSP;
				next_seq_err = !c_d0;
			end
			fcsm_pkg::FCSM_BP_BUSY:
				if (c_b0) next_state = fcsm_pkg::FCSM_BP_SUSP;
				else if (done) next_state = fcsm_pkg::FCSM_READY;
			fcsm_pkg::FCSM_BP_SUSP:
				if (c_d0) next_state = fcsm_pkg::FCSM_BP_BUSY;
			fcsm_pkg::FCSM_ER_SETUP: if (wr) begin
				next_state   = c_d0 ? fcsm_pkg::FCSM_ER_BUSY :
				               fcsm_pkg::FCSM_READY;
				next_seq_err = !c_d0;
			end
			fcsm_pkg::FCSM_ER_BUSY:
				if (c_b0) next_state = fcsm_pkg::FCSM_ER_SUSP;
				else if (done) next_state = fcsm_pkg::FCSM_READY;
			fcsm_pkg::FCSM_ER_SUSP:
				if (c_wp) next_state = fcsm_pkg::FCSM_ES_WP_SETUP;
				else if (c_bp) next_state = fcsm_pkg::FCSM_ES_BP_SETUP;
				else if (c_lock) next_state = fcsm_pkg::FCSM_ES_LOCK;
				else if (c_d0) next_state = fcsm_pkg::FCSM_ER_BUSY;
			fcsm_pkg::FCSM_ES_WP_SETUP:
				if (wr) next_state = fcsm_pkg::FCSM_ES_WP_BUSY;
			fcsm_pkg::FCSM_ES_WP_BUSY:
				if (c_b0) next_state = fcsm_pkg::FCSM_ES_WP_SUSP;
				else if (done) next_state = fcsm_pkg::FCSM_ER_SUSP;
			fcsm_pkg::FCSM_ES_WP_SUSP:
				if (c_d0) next_state = fcsm_pkg::FCSM_ES_WP_BUSY;
			fcsm_pkg::FCSM_ES_BP_BUSY:
				if (c_b0) next_state = fcsm_pkg::FCSM_ES_BP_SUSP;
				else if (done) next_state = fcsm_pkg::FCSM_ER_SUSP;
			fcsm_pkg::FCSM_ES_BP_SUSP:
				if (c_d0) next_state = fcsm_pkg::FCSM_ES_BP_BUSY;
			fcsm_pkg::FCSM_ES_LOCK: if (wr) begin
				next_state    = fcsm_pkg::FCSM_ER_SUSP;
				next_lock_err = !c_d0 && code != 8'h01 && code != 8'h2F &&
				                code != 8'h03 &&
				                code != fcsm_pkg::CMD_LOCK_SETUP;
			end
			default: next_state = fcsm_pkg::FCSM_READY;
		endcase
	end

	// owning partition latched only when an operation starts from ready
	wire       start_op  = (state == fcsm_pkg::FCSM_READY) &&
	                       (c_wp || c_bp || c_er || c_fact);
	wire [fcsm_pkg::PART_W-1:0] next_op_part = start_op ? i_cmd.part :
	                                          o_op_part;

	// read output selection per partition, only from read commands
	wire rd_cmd = wr && (code == fcsm_pkg::CMD_READ_ARRAY ||
	                     code == fcsm_pkg::CMD_READ_ID ||
	                     code == fcsm_pkg::CMD_QUERY ||
	                     code == fcsm_pkg::CMD_READ_STATUS);
	// data words during loading must not retarget the read state
	wire loading = (state == fcsm_pkg::FCSM_BP_SETUP ||
	                state == fcsm_pkg::FCSM_BP_LOAD1 ||
	                state == fcsm_pkg::FCSM_BP_LOAD2 ||
	                state == fcsm_pkg::FCSM_ES_BP_SETUP ||
	                state == fcsm_pkg::FCSM_ES_BP_LOAD1 ||
	                state == fcsm_pkg::FCSM_ES_BP_LOAD2 ||
	                state == fcsm_pkg::FCSM_WP_SETUP ||
	                state == fcsm_pkg::FCSM_ES_WP_SETUP);
	// a data word of 50 must not wipe the sticky errors
	wire clr_status = wr && code == fcsm_pkg::CMD_CLR_STATUS && !loading;
	wire fcsm_pkg::fcsm_rd_e rd_sel =
		(code == fcsm_pkg::CMD_QUERY)  ? fcsm_pkg::FCSM_RD_QUERY :
		(code == fcsm_pkg::CMD_READ_ID) ? fcsm_pkg::FCSM_RD_ID :
		(code == fcsm_pkg::CMD_READ_STATUS) ? fcsm_pkg::FCSM_RD_STATUS :
		fcsm_pkg::FCSM_RD_ARRAY;

	fcsm_rd_mem u_rd_mem (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_we      (rd_cmd && !loading),
		.i_wpart   (i_cmd.part),
		.i_wdata   (rd_sel),
		.i_rpart   (i_rd_part),
		.o_rdata   (o_rd_state)
	);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state        <= fcsm_pkg::FCSM_READY;
			wcnt         <= fcsm_pkg::WCNT_ZERO;
			o_op_part    <= '0;
			o_seq_error  <= 1'b0;
			o_lock_error <= 1'b0;
		end else begin
			state        <= next_state;
			wcnt         <= next_wcnt;
			o_op_part    <= next_op_part;
			// sticky until clear status; a new error wins over the clear
			o_seq_error  <= next_seq_err || (o_seq_error && !clr_status);
			o_lock_error <= next_lock_err || (o_lock_error && !clr_status);
		end
	end

	assign o_state = state;
	assign o_busy  = is_busy(state);

endmodule : fcsm_top

/* test/fcsm_host.sv */
// host model: command writes and array engine done pulses
`timescale 1ns/1ps
module fcsm_host (
	// clock
	input  wire logic           i_sys_clk,
	// host bus and engine done
	output fcsm_pkg::fcsm_cmd_s o_cmd,
	output logic                o_op_done
);
	initial o_cmd = '0;
	initial o_op_done = 1'b0;
	// strobe up for one taken edge; code flips once released
	task automatic wr(input logic [2:0] p, input logic [7:0] c);
		@(posedge i_sys_clk);
		o_cmd <= '{1'b1, p, c};
		@(posedge i_sys_clk);
		o_cmd <= '{1'b0, p, ~c};
	endtask : wr
	task automatic load(input logic [2:0] p, input logic [4:0] n);
		wr(p, {3'h0, n - 5'h1});
		for (int k = 0; k < int'(n); k++)
			wr(p, 8'hA0 + 8'(k));
	endtask : load
	task automatic done;
		@(posedge i_sys_clk);
		o_op_done <= 1'b1;
		@(posedge i_sys_clk);
		o_op_done <= 1'b0;
	endtask : done
endmodule : fcsm_host

/* test/fcsm_monitor.sv */
// checker: port assertions on the command state machine
`timescale 1ns/1ps
module fcsm_monitor (
	// clock and reset
	input wire logic                        i_sys_clk,
	input wire logic                        i_rst_n,
	// watched ports
	input wire fcsm_pkg::fcsm_cmd_s         i_cmd,
	input wire logic [fcsm_pkg::PART_W-1:0] i_rd_part,
	input wire fcsm_pkg::fcsm_rd_e          o_rd_state,
	input wire logic                        i_op_done,
	input wire fcsm_pkg::fcsm_state_e       o_state,
	input wire logic [fcsm_pkg::PART_W-1:0] o_op_part,
	input wire logic                        o_busy,
	input wire logic                        o_seq_error,
	input wire logic                        o_lock_error
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	// code 00 is unused, so it stands for no write
	wire logic [7:0]            c = i_cmd.valid ? i_cmd.code : 8'h00;
	wire fcsm_pkg::fcsm_state_e s = o_state;
	property p_rdy_er;
		s == fcsm_pkg::FCSM_READY && c == 8'h20 |=> s == fcsm_pkg::FCSM_ER_SETUP;
	endproperty
	a_rdy_er: assert property (p_rdy_er) else $error("no erase setup");
	property p_wp_susp;
		s == fcsm_pkg::FCSM_WP_BUSY && c == 8'hB0 && !i_op_done
		|=> s == fcsm_pkg::FCSM_WP_SUSP;
	endproperty
	a_wp_susp: assert property (p_wp_susp) else $error("no suspend");
	property p_wp_res;
		s == fcsm_pkg::FCSM_WP_SUSP && c == 8'hD0 |=> s == fcsm_pkg::FCSM_WP_BUSY;
	endproperty
	a_wp_res: assert property (p_wp_res) else $error("no resume");
	property p_er_conf;
		s == fcsm_pkg::FCSM_ER_SETUP && i_cmd.valid && c != 8'hD0
		|=> s == fcsm_pkg::FCSM_READY && o_seq_error;
	endproperty
	a_er_conf: assert property (p_er_conf) else $error("bad confirm");
	property p_es_nest;
		s == fcsm_pkg::FCSM_ER_SUSP && c == 8'h40
		|=> s == fcsm_pkg::FCSM_ES_WP_SETUP;
	endproperty
	a_es_nest: assert property (p_es_nest) else $error("no nesting");
	property p_query;
		s == fcsm_pkg::FCSM_READY && c == 8'h98 && i_cmd.part == i_rd_part
		##1 $stable(i_rd_part) |=> o_rd_state == fcsm_pkg::FCSM_RD_QUERY;
	endproperty
	a_query: assert property (p_query) else $error("no query read");
	property p_owner;
		o_busy ##1 o_busy |-> $stable(o_op_part);
	endproperty
	a_owner: assert property (p_owner) else $error("owner moved");
	property p_done;
		s == fcsm_pkg::FCSM_ER_BUSY && i_op_done && !i_cmd.valid
		|=> s == fcsm_pkg::FCSM_READY;
	endproperty
	a_done: assert property (p_done) else $error("erase end lost");
endmodule : fcsm_monitor
bind fcsm_top fcsm_monitor u_mon (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd),
	.i_rd_part(i_rd_part), .o_rd_state(o_rd_state), .i_op_done(i_op_done),
	.o_state(o_state), .o_op_part(o_op_part), .o_busy(o_busy),
	.o_seq_error(o_seq_error), .o_lock_error(o_lock_error)
);

/* test/tb.sv */
// testbench: directed scenarios for the command state machine
`timescale 1ns/1ps
module tb;
	logic                        i_sys_clk = 1'b0;
	logic                        i_rst_n = 1'b0;
	logic [fcsm_pkg::PART_W-1:0] rd_part = 3'h0;
	logic [fcsm_pkg::PART_W-1:0] op_part;
	fcsm_pkg::fcsm_cmd_s         cmd;
	fcsm_pkg::fcsm_rd_e          rd_st;
	fcsm_pkg::fcsm_state_e       st;
	logic                        op_done, busy, seq_err, lock_err;
	int                          err_count = 0;
	int                          checks_done = 0;
	fcsm_top dut (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd(cmd),
		.i_rd_part(rd_part), .o_rd_state(rd_st), .i_op_done(op_done),
		.o_state(st), .o_op_part(op_part), .o_busy(busy),
		.o_seq_error(seq_err), .o_lock_error(lock_err)
	);
	fcsm_host host (.i_sys_clk(i_sys_clk), .o_cmd(cmd), .o_op_done(op_done));
	always #50 i_sys_clk = ~i_sys_clk;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	// write, then look at the state once the edge has landed
	task automatic w(input logic [2:0] p, input logic [7:0] c,
		input fcsm_pkg::fcsm_state_e e);
		if (c != 8'h00)
			host.wr(p, c);
		@(negedge i_sys_clk);
		chk("state", e, st);
	endtask : w
	task automatic rd(input logic [2:0] p, input fcsm_pkg::fcsm_rd_e e);
		@(posedge i_sys_clk);
		rd_part <= p;
		repeat (2) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk("read state", {3'h0, e}, {3'h0, rd_st});
	endtask : rd
	task automatic rst;
		@(posedge i_sys_clk);
		i_rst_n <= 1'b0;
		@(posedge i_sys_clk);
		i_rst_n <= 1'b1;
	endtask : rst
	task automatic t_ready;
		logic [7:0] c [12] = '{8'h10, 8'h40, 8'hE8, 8'h20, 8'h60, 8'h80,
			8'hFF, 8'h70, 8'h50, 8'h90, 8'hD0, 8'hB0};
		fcsm_pkg::fcsm_state_e s [6] = '{fcsm_pkg::FCSM_WP_SETUP,
			fcsm_pkg::FCSM_WP_SETUP, fcsm_pkg::FCSM_BP_SETUP,
			fcsm_pkg::FCSM_ER_SETUP, fcsm_pkg::FCSM_LOCK_SETUP,
			fcsm_pkg::FCSM_FACT_SETUP};
		for (int k = 0; k < 12; k++) begin
			rst();
			w(3'h0, c[k], k < 6 ? s[k] : fcsm_pkg::FCSM_READY);
		end
		$display("test ready codes done");
	endtask : t_ready
	task automatic t_word;
		rst();
		w(3'h6, 8'h40, fcsm_pkg::FCSM_WP_SETUP);
		w(3'h6, 8'h5A, fcsm_pkg::FCSM_WP_BUSY);
		chk("busy", 5'h1, {4'h0, busy});
		w(3'h2, 8'h20, fcsm_pkg::FCSM_WP_BUSY);
		chk("owner", 5'h6, {2'h0, op_part});
		w(3'h6, 8'hB0, fcsm_pkg::FCSM_WP_SUSP);
		w(3'h6, 8'hFF, fcsm_pkg::FCSM_WP_SUSP);
		w(3'h6, 8'hD0, fcsm_pkg::FCSM_WP_BUSY);
		host.done();
		w(3'h6, 8'h00, fcsm_pkg::FCSM_READY);
		$display("test word program done");
	endtask : t_word
	task automatic t_query;
		rd(3'h3, fcsm_pkg::FCSM_RD_ARRAY);
		w(3'h3, 8'h98, fcsm_pkg::FCSM_READY);
		w(3'h5, 8'h90, fcsm_pkg::FCSM_READY);
		rd(3'h3, fcsm_pkg::FCSM_RD_QUERY);
		rd(3'h5, fcsm_pkg::FCSM_RD_ID);
		$display("test read states done");
	endtask : t_query
	task automatic t_erase;
		w(3'h1, 8'h20, fcsm_pkg::FCSM_ER_SETUP);
		w(3'h1, 8'h70, fcsm_pkg::FCSM_READY);
		chk("seq error", 5'h1, {4'h0, seq_err});
		w(3'h1, 8'h50, fcsm_pkg::FCSM_READY);
		chk("seq error", 5'h0, {4'h0, seq_err});
		w(3'h1, 8'h20, fcsm_pkg::FCSM_ER_SETUP);
		w(3'h1, 8'hD0, fcsm_pkg::FCSM_ER_BUSY);
		w(3'h1, 8'hB0, fcsm_pkg::FCSM_ER_SUSP);
		w(3'h1, 8'h60, fcsm_pkg::FCSM_ES_LOCK);
		w(3'h1, 8'h01, fcsm_pkg::FCSM_ER_SUSP);
		chk("lock error", 5'h0, {4'h0, lock_err});
		w(3'h1, 8'h40, fcsm_pkg::FCSM_ES_WP_SETUP);
		w(3'h1, 8'h11, fcsm_pkg::FCSM_ES_WP_BUSY);
		host.done();
		w(3'h1, 8'h00, fcsm_pkg::FCSM_ER_SUSP);
		w(3'h1, 8'hE8, fcsm_pkg::FCSM_ES_BP_SETUP);
		host.load(3'h1, 5'h1);
		w(3'h1, 8'hFF, fcsm_pkg::FCSM_ER_SUSP);
		chk("seq error", 5'h1, {4'h0, seq_err});
		w(3'h1, 8'h50, fcsm_pkg::FCSM_ER_SUSP);
		chk("seq error", 5'h0, {4'h0, seq_err});
		w(3'h1, 8'hD0, fcsm_pkg::FCSM_ER_BUSY);
		host.done();
		w(3'h1, 8'h00, fcsm_pkg::FCSM_READY);
		rd(3'h5, fcsm_pkg::FCSM_RD_ID);
		$display("test erase done");
	endtask : t_erase
	task automatic t_buf;
		w(3'h4, 8'hE8, fcsm_pkg::FCSM_BP_SETUP);
		host.load(3'h4, 5'h3);
		w(3'h4, 8'h00, fcsm_pkg::FCSM_BP_CONFIRM);
		w(3'h4, 8'hD0, fcsm_pkg::FCSM_BP_BUSY);
		host.done();
		w(3'h4, 8'h00, fcsm_pkg::FCSM_READY);
		w(3'h4, 8'hE8, fcsm_pkg::FCSM_BP_SETUP);
		host.load(3'h4, 5'h1);
		w(3'h4, 8'h20, fcsm_pkg::FCSM_READY);
		chk("seq error", 5'h1, {4'h0, seq_err});
		w(3'h4, 8'h60, fcsm_pkg::FCSM_LOCK_SETUP);
		w(3'h4, 8'hFF, fcsm_pkg::FCSM_READY);
		chk("lock error", 5'h1, {4'h0, lock_err});
		w(3'h4, 8'h50, fcsm_pkg::FCSM_READY);
		chk("lock error", 5'h0, {4'h0, lock_err});
		chk("seq error", 5'h0, {4'h0, seq_err});
		$display("test buffered program done");
	endtask : t_buf
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_ready();
		t_word();
		t_query();
		t_erase();
		t_buf();
		wrap_up();
	end
endmodule : tb
